/* File: rtl/fis_top.sv */
// fault status flags with paired-write clear, enables and interrupt line
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module fis_top (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [6:0] sys_fault_evt,
    input wire logic [5:0] chan_fault_evt,
    input wire logic string_open_evt,
    input wire logic string_short_evt,
    output logic irq
);
    fis_pkg::fis_state_t st;
    fis_pkg::fis_state_t next_st;
    logic wr_stat1;
    logic wr_stat2;
    logic wr_en1;
    logic wr_en2;
    logic [fis_pkg::N_SYS-1:0] sys_ack;
    logic [fis_pkg::N_SYS-1:0] sys_en;
    logic sum_ack;
    logic led_evt;

    ////////////////////////////////////////////////////////////////////////
    // address decode
    assign wr_stat1 = reg_wr && (reg_addr == fis_pkg::OFF_STAT1);
    assign wr_stat2 = reg_wr && (reg_addr == fis_pkg::OFF_STAT2);
    assign wr_en1 = reg_wr && (reg_addr == fis_pkg::OFF_EN1);
    assign wr_en2 = reg_wr && (reg_addr == fis_pkg::OFF_EN2);

    // both bits of the pair must be one; a lone bit is no ack
    for (genvar g = 0; g < fis_pkg::N_SYS; g++) begin : g_sys
        assign sys_ack[g] = wr_stat1 && reg_wdata[fis_pkg::SYS_POS[g]]
            && reg_wdata[fis_pkg::SYS_POS[g] - 1];
        assign sys_en[g] = st.en[fis_pkg::SYS_EN[g]];
    end
    assign sum_ack = wr_stat2 && reg_wdata[fis_pkg::SUM_POS]
        && reg_wdata[fis_pkg::SUM_ACK_POS];
    assign led_evt = (|chan_fault_evt) || string_open_evt || string_short_evt;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        // read data stands only in the cycle after the strobe
        next_st.rdata = '0;
        // set beats clear so an event in the ack cycle is kept
        next_st.sys_flag = (st.sys_flag & ~sys_ack) | sys_fault_evt;
        next_st.sum_flag = (st.sum_flag & ~sum_ack) | led_evt;
        next_st.chan_flag = (st.chan_flag & ~{fis_pkg::N_CHAN{sum_ack}})
            | chan_fault_evt;
        next_st.open_flag = (st.open_flag & ~sum_ack) | string_open_evt;
        next_st.short_flag = (st.short_flag & ~sum_ack) | string_short_evt;
        for (int i = 0; i < fis_pkg::N_EN; i++) begin
            if ((i == fis_pkg::EN_LED) ? wr_en2 : wr_en1) begin
                if (reg_wdata[fis_pkg::EN_POS[i] +: 2] == fis_pkg::EN_WR_ON) begin
                    next_st.en[i] = 1'b1;
                end else if (reg_wdata[fis_pkg::EN_POS[i] +: 2] == fis_pkg::EN_WR_OFF) begin
                    next_st.en[i] = 1'b0;
                end
            end
        end
        if (reg_rd) begin
            if (reg_addr == fis_pkg::OFF_STAT1) begin
                for (int i = 0; i < fis_pkg::N_SYS; i++) begin
                    next_st.rdata[fis_pkg::SYS_POS[i]] = st.sys_flag[i];
                end
            end else if (reg_addr == fis_pkg::OFF_STAT2) begin
                next_st.rdata[fis_pkg::CHAN0_POS +: fis_pkg::N_CHAN] = st.chan_flag;
                next_st.rdata[fis_pkg::OPEN_POS] = st.open_flag;
                next_st.rdata[fis_pkg::SHORT_POS] = st.short_flag;
                next_st.rdata[fis_pkg::SUM_POS] = st.sum_flag;
            end else if (reg_addr == fis_pkg::OFF_EN1) begin
                for (int i = 0; i < fis_pkg::EN_LED; i++) begin
                    next_st.rdata[fis_pkg::EN_POS[i] +: 2] =
                        st.en[i] ? fis_pkg::EN_RD_ON : 2'h0;
                end
            end else if (reg_addr == fis_pkg::OFF_EN2) begin
                next_st.rdata[fis_pkg::EN_POS[fis_pkg::EN_LED] +: 2] =
                    st.en[fis_pkg::EN_LED] ? fis_pkg::EN_RD_ON : 2'h0;
            end
        end
        // registered from the next state so the pin tracks flags with no lag
        next_st.irq = next_st.en[fis_pkg::EN_GLOBAL]
            && ((|(next_st.sys_flag & sys_en_next(next_st)))
            || (next_st.sum_flag && next_st.en[fis_pkg::EN_LED]));
    end

    function automatic logic [fis_pkg::N_SYS-1:0] sys_en_next(input fis_pkg::fis_state_t s);
        logic [fis_pkg::N_SYS-1:0] m;
        m = '0;
        for (int i = 0; i < fis_pkg::N_SYS; i++) begin
            m[i] = s.en[fis_pkg::SYS_EN[i]];
        end
        return m;
    endfunction

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st <= fis_pkg::STATE_RST;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign irq = st.irq;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    property p_pair_clear;
        ce && sys_ack[0] && !sys_fault_evt[0] |=> !st.sys_flag[0];
    endproperty
    a_pair_clear: assert property (p_pair_clear) else $error("paired ack did not clear");

    property p_lone_keep;
        ce && st.sys_flag[1] && wr_stat1 && reg_wdata[13] && !reg_wdata[12]
            |=> st.sys_flag[1];
    endproperty
    a_lone_keep: assert property (p_lone_keep) else $error("lone status write cleared");

    property p_set_read;
        ce && sys_fault_evt[6] ##1 ce && reg_rd && reg_addr == fis_pkg::OFF_STAT1
            && !sys_ack[6] |=> reg_rdata[1];
    endproperty
    a_set_read: assert property (p_set_read) else $error("fault not read as one");

    property p_reset_zero;
        @(posedge mclk) disable iff (1'b0) !rstn |=> st.sys_flag == '0 && st.chan_flag == '0
            && !irq && reg_rdata == '0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("reset values wrong");

    property p_reserved;
        ce && reg_rd && reg_addr == fis_pkg::OFF_STAT1 |=> reg_rdata[9:8] == 2'h0
            && reg_rdata[14] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved or ack bit nonzero");

    property p_detail_clear;
        ce && sum_ack && !led_evt |=> st.chan_flag == '0 && !st.open_flag && !st.sum_flag;
    endproperty
    a_detail_clear: assert property (p_detail_clear) else $error("detail bits kept");

    property p_chan_sets_sum;
        ce && chan_fault_evt[5] |=> st.chan_flag[5] && st.sum_flag;
    endproperty
    a_chan_sets_sum: assert property (p_chan_sets_sum) else $error("channel fault lost");

    property p_en_write;
        ce && wr_en1 && reg_wdata[fis_pkg::EN_POS[fis_pkg::EN_GLOBAL] +: 2] == 2'h1
            |=> !st.en[fis_pkg::EN_GLOBAL] && !irq;
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable encoding wrong");

    property p_irq_global;
        !st.en[fis_pkg::EN_GLOBAL] |-> !irq;
    endproperty
    a_irq_global: assert property (p_irq_global) else $error("irq with global off");

    property p_irq_tsd;
        ce && sys_fault_evt[6] && st.en[0] && st.en[6] && !(wr_en1) |=> irq;
    endproperty
    a_irq_tsd: assert property (p_irq_tsd) else $error("irq missing");

    property p_ovh_clear;
        ce && wr_stat1 && reg_wdata[fis_pkg::SYS_POS[0]]
            && reg_wdata[fis_pkg::SYS_POS[0] - 1] && !sys_fault_evt[0] |=> !st.sys_flag[0];
    endproperty
    a_ovh_clear: assert property (p_ovh_clear) else $error("overvolt high not cleared");

    property p_hot_clear;
        ce && wr_stat1 && reg_wdata[fis_pkg::SYS_POS[1]]
            && reg_wdata[fis_pkg::SYS_POS[1] - 1] && !sys_fault_evt[1] |=> !st.sys_flag[1];
    endproperty
    a_hot_clear: assert property (p_hot_clear) else $error("hot flag not cleared");

    property p_cold_clear;
        ce && wr_stat1 && reg_wdata[fis_pkg::SYS_POS[2]]
            && reg_wdata[fis_pkg::SYS_POS[2] - 1] && !sys_fault_evt[2] |=> !st.sys_flag[2];
    endproperty
    a_cold_clear: assert property (p_cold_clear) else $error("cold flag not cleared");

    property p_ovl_clear;
        ce && wr_stat1 && reg_wdata[fis_pkg::SYS_POS[3]]
            && reg_wdata[fis_pkg::SYS_POS[3] - 1] && !sys_fault_evt[3] |=> !st.sys_flag[3];
    endproperty
    a_ovl_clear: assert property (p_ovl_clear) else $error("overvolt low not cleared");

    property p_overcur_clear;
        ce && wr_stat1 && reg_wdata[fis_pkg::SYS_POS[4]]
            && reg_wdata[fis_pkg::SYS_POS[4] - 1] && !sys_fault_evt[4] |=> !st.sys_flag[4];
    endproperty
    a_overcur_clear: assert property (p_overcur_clear) else $error("overcurrent not cleared");

    property p_lock_clear;
        ce && wr_stat1 && reg_wdata[fis_pkg::SYS_POS[5]]
            && reg_wdata[fis_pkg::SYS_POS[5] - 1] && !sys_fault_evt[5] |=> !st.sys_flag[5];
    endproperty
    a_lock_clear: assert property (p_lock_clear) else $error("lockout not cleared");

    property p_shutdown_clear;
        ce && wr_stat1 && reg_wdata[fis_pkg::SYS_POS[6]]
            && reg_wdata[fis_pkg::SYS_POS[6] - 1] && !sys_fault_evt[6] |=> !st.sys_flag[6];
    endproperty
    a_shutdown_clear: assert property (p_shutdown_clear) else $error("shutdown not cleared");

    // a write without the ack bit must leave each flag alone
    property p_ovh_keep;
        ce && st.sys_flag[0] && wr_stat1 && !reg_wdata[fis_pkg::SYS_POS[0] - 1] |=> st.sys_flag[0];
    endproperty
    a_ovh_keep: assert property (p_ovh_keep) else $error("overvolt high lost");

    property p_hot_keep;
        ce && st.sys_flag[1] && wr_stat1 && !reg_wdata[fis_pkg::SYS_POS[1] - 1] |=> st.sys_flag[1];
    endproperty
    a_hot_keep: assert property (p_hot_keep) else $error("hot flag lost");

    property p_cold_keep;
        ce && st.sys_flag[2] && wr_stat1 && !reg_wdata[fis_pkg::SYS_POS[2] - 1] |=> st.sys_flag[2];
    endproperty
    a_cold_keep: assert property (p_cold_keep) else $error("cold flag lost");

    property p_ovl_keep;
        ce && st.sys_flag[3] && wr_stat1 && !reg_wdata[fis_pkg::SYS_POS[3] - 1] |=> st.sys_flag[3];
    endproperty
    a_ovl_keep: assert property (p_ovl_keep) else $error("overvolt low lost");

    property p_overcur_keep;
        ce && st.sys_flag[4] && wr_stat1 && !reg_wdata[fis_pkg::SYS_POS[4] - 1] |=> st.sys_flag[4];
    endproperty
    a_overcur_keep: assert property (p_overcur_keep) else $error("overcurrent lost");

    property p_lock_keep;
        ce && st.sys_flag[5] && wr_stat1 && !reg_wdata[fis_pkg::SYS_POS[5] - 1] |=> st.sys_flag[5];
    endproperty
    a_lock_keep: assert property (p_lock_keep) else $error("lockout lost");

    property p_shutdown_keep;
        ce && st.sys_flag[6] && wr_stat1 && !reg_wdata[fis_pkg::SYS_POS[6] - 1] |=> st.sys_flag[6];
    endproperty
    a_shutdown_keep: assert property (p_shutdown_keep) else $error("shutdown lost");

    // every detected system fault ends up latched, refault included
    property p_set_any;
        ce |=> (st.sys_flag & $past(sys_fault_evt)) == $past(sys_fault_evt);
    endproperty
    a_set_any: assert property (p_set_any) else $error("fault not latched");

    property p_open_set;
        ce && string_open_evt |=> st.open_flag && st.sum_flag;
    endproperty
    a_open_set: assert property (p_open_set) else $error("open string lost");

    property p_short_set;
        ce && string_short_evt |=> st.short_flag && st.sum_flag;
    endproperty
    a_short_set: assert property (p_short_set) else $error("short string lost");

    property p_open_read;
        ce && reg_rd && reg_addr == fis_pkg::OFF_STAT2
            |=> reg_rdata[fis_pkg::OPEN_POS] == $past(st.open_flag);
    endproperty
    a_open_read: assert property (p_open_read) else $error("open bit misread");

    property p_chan_read;
        ce && reg_rd && reg_addr == fis_pkg::OFF_STAT2
            |=> reg_rdata[fis_pkg::CHAN0_POS +: fis_pkg::N_CHAN] == $past(st.chan_flag);
    endproperty
    a_chan_read: assert property (p_chan_read) else $error("channel bits misread");

    property p_stat2_reserved;
        ce && reg_rd && reg_addr == fis_pkg::OFF_STAT2
            |=> reg_rdata[fis_pkg::SUM_ACK_POS:0] == '0;
    endproperty
    a_stat2_reserved: assert property (p_stat2_reserved) else $error("led reserved nonzero");

    property p_stat1_read;
        ce && reg_rd && reg_addr == fis_pkg::OFF_STAT1
            |=> reg_rdata[fis_pkg::SYS_POS[6]] == $past(st.sys_flag[6]);
    endproperty
    a_stat1_read: assert property (p_stat1_read) else $error("shutdown bit misread");

    // read data must not linger past its one cycle
    property p_rdata_idle;
        ce && !reg_rd |=> reg_rdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data lingers");

    property p_en_on;
        ce && wr_en1 && reg_wdata[fis_pkg::EN_POS[fis_pkg::EN_GLOBAL] +: 2] == fis_pkg::EN_WR_ON
            |=> st.en[fis_pkg::EN_GLOBAL];
    endproperty
    a_en_on: assert property (p_en_on) else $error("global enable not set");

    property p_en_hold;
        ce && wr_en1 && reg_wdata[fis_pkg::EN_POS[fis_pkg::EN_GLOBAL] +: 2] == 2'h2
            |=> st.en[fis_pkg::EN_GLOBAL] == $past(st.en[fis_pkg::EN_GLOBAL]);
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("ignored code changed enable");

    property p_led_en_off;
        ce && wr_en2 && reg_wdata[fis_pkg::EN_POS[fis_pkg::EN_LED] +: 2] == fis_pkg::EN_WR_OFF
            |=> !st.en[fis_pkg::EN_LED];
    endproperty
    a_led_en_off: assert property (p_led_en_off) else $error("led enable not cleared");

    property p_irq_led;
        ce && led_evt && st.en[fis_pkg::EN_GLOBAL] && st.en[fis_pkg::EN_LED] && !reg_wr |=> irq;
    endproperty
    a_irq_led: assert property (p_irq_led) else $error("led irq missing");

    property p_irq_none;
        st.sys_flag == '0 && !st.sum_flag |-> !irq;
    endproperty
    a_irq_none: assert property (p_irq_none) else $error("irq with no flag");

    // pin and latched state always agree, ce low included
    property p_irq_sys;
        st.en[fis_pkg::EN_GLOBAL] && (|(st.sys_flag & sys_en)) |-> irq;
    endproperty
    a_irq_sys: assert property (p_irq_sys) else $error("system irq missing");

    property p_sum_keep;
        ce && st.sum_flag && !(wr_stat2 && reg_wdata[fis_pkg::SUM_ACK_POS]) |=> st.sum_flag;
    endproperty
    a_sum_keep: assert property (p_sum_keep) else $error("summary flag lost");

    property p_freeze;
        !ce |=> st == $past(st);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with enable low");

    c_clear: cover property (ce && st.sys_flag[0] && sys_ack[0] ##1 !st.sys_flag[0]);
    c_led: cover property (ce && st.sum_flag && sum_ack ##1 !st.sum_flag);
    c_irq: cover property (!irq ##1 irq ##[1:20] !irq);
endmodule

/* File: rtl/fis_pkg.sv */
// constants, register map and state type of the fault status block
package fis_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int N_SYS = 7;
    localparam int N_CHAN = 6;
    localparam int N_EN = 8;

    localparam logic [7:0] OFF_EN1 = 8'h50;
    localparam logic [7:0] OFF_EN2 = 8'h52;
    localparam logic [7:0] OFF_STAT1 = 8'h54;
    localparam logic [7:0] OFF_STAT2 = 8'h56;

    // system flags, index 0..6: overvolt high, hot, cold, overvolt low,
    // overcurrent, supply lockout, thermal shutdown; ack bit sits one below
    localparam int SYS_POS [N_SYS] = '{15, 13, 11, 7, 5, 3, 1};
    // enable index guarding each system flag (hot and cold share one)
    localparam int SYS_EN [N_SYS] = '{1, 2, 2, 3, 4, 5, 6};

    // led fault register layout
    localparam int CHAN0_POS = 10;
    localparam int OPEN_POS = 9;
    localparam int SHORT_POS = 8;
    localparam int SUM_POS = 7;
    localparam int SUM_ACK_POS = 6;

    // enable index 0 global, 1..6 system groups, 7 led; low bit of field
    localparam int EN_POS [N_EN] = '{14, 12, 10, 6, 4, 2, 0, 6};
    localparam int EN_GLOBAL = 0;
    localparam int EN_LED = 7;
    localparam logic [1:0] EN_WR_ON = 2'h3;
    localparam logic [1:0] EN_WR_OFF = 2'h1;
    localparam logic [1:0] EN_RD_ON = 2'h2;
    localparam logic [7:0] EN_RST = 8'hf3;

    typedef struct packed {
        logic [N_SYS-1:0] sys_flag;
        logic [N_CHAN-1:0] chan_flag;
        logic open_flag;
        logic short_flag;
        logic sum_flag;
        logic [N_EN-1:0] en;
        logic [DATA_W-1:0] rdata;
        logic irq;
    } fis_state_t;

    localparam fis_state_t STATE_RST = '{
        sys_flag: '0, chan_flag: '0, open_flag: 1'b0, short_flag: 1'b0,
        sum_flag: 1'b0, en: EN_RST, rdata: '0, irq: 1'b0};
endpackage

/* File: verification/test_fault_interrupt_status_clear.sv */
// self-checking bench for the fault flag block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_fault_interrupt_status_clear;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [6:0] sys_fault_evt = 7'h00;
    logic [5:0] chan_fault_evt = 6'h00;
    logic string_open_evt = 1'b0;
    logic string_short_evt = 1'b0;
    logic irq;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [15:0] rv;
    // own copy of flag positions so a wrong map in the design shows up
    int pos [7] = '{15, 13, 11, 7, 5, 3, 1};
    // reset enables: temperature and overvolt low start masked
    logic [6:0] en_rst = 7'b1110001;

    always #20 mclk = ~mclk;

    fis_top i_fis_top (
        .mclk(mclk),
        .rstn(rstn),
        .ce(ce),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .sys_fault_evt(sys_fault_evt),
        .chan_fault_evt(chan_fault_evt),
        .string_open_evt(string_open_evt),
        .string_short_evt(string_short_evt),
        .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic chk_rd(input string n, input logic [7:0] a, input logic [15:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
        `CHK(n, e, rv)
        @(posedge mclk);
        #1;
        `CHK("rd idle", 16'h0000, reg_rdata)
    endtask

    // one-cycle detector pulse; flags land at the edge that ends it
    task automatic hit(input logic [6:0] s, input logic [5:0] c, input logic o, input logic h);
        @(posedge mclk);
        sys_fault_evt <= s;
        chan_fault_evt <= c;
        string_open_evt <= o;
        string_short_evt <= h;
        @(posedge mclk);
        sys_fault_evt <= 7'h00;
        chan_fault_evt <= 6'h00;
        string_open_evt <= 1'b0;
        string_short_evt <= 1'b0;
        #1;
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        #1;
        `CHK("irq rst", 1'b0, irq)
        chk_rd("stat1 rst", 8'h54, 16'h0000);
        chk_rd("stat2 rst", 8'h56, 16'h0000);
        chk_rd("en1 rst", 8'h50, 16'ha02a);
        chk_rd("en2 rst", 8'h52, 16'h0080);
        chk_rd("unmapped", 8'h60, 16'h0000);
        // enable low: a detector pulse must not latch
        @(posedge mclk);
        ce <= 1'b0;
        hit(7'h40, 6'h00, 1'b0, 1'b0);
        @(posedge mclk);
        ce <= 1'b1;
        `CHK("irq frozen", 1'b0, irq)
        chk_rd("ce frozen", 8'h54, 16'h0000);
        for (int i = 0; i < 7; i++) begin
            hit(7'h01 << i, 6'h00, 1'b0, 1'b0);
            chk_rd("flag set", 8'h54, 16'h0001 << pos[i]);
            `CHK("irq set", en_rst[i], irq)
            wr(8'h54, 16'h0001 << pos[i]);
            wr(8'h54, 16'h0001 << (pos[i] - 1));
            chk_rd("lone write", 8'h54, 16'h0001 << pos[i]);
            wr(8'h54, 16'h0003 << (pos[i] - 1));
            chk_rd("pair clear", 8'h54, 16'h0000);
            `CHK("irq clear", 1'b0, irq)
        end
        // all at once, twice: refault keeps flags, reserved write inert
        hit(7'h7f, 6'h00, 1'b0, 1'b0);
        hit(7'h7f, 6'h00, 1'b0, 1'b0);
        wr(8'h54, 16'h0300);
        chk_rd("all flags", 8'h54, 16'ha8aa);
        wr(8'h54, 16'hfcff);
        chk_rd("all clear", 8'h54, 16'h0000);
        for (int c = 0; c < 6; c++) begin
            hit(7'h00, 6'h01 << c, 1'b0, 1'b0);
            chk_rd("chan set", 8'h56, (16'h0400 << c) | 16'h0080);
            `CHK("irq led", 1'b1, irq)
            wr(8'h56, 16'h00c0);
            chk_rd("chan clear", 8'h56, 16'h0000);
        end
        hit(7'h00, 6'h00, 1'b1, 1'b1);
        chk_rd("open short", 8'h56, 16'h0380);
        wr(8'h56, 16'h003f);
        wr(8'h56, 16'h0080);
        chk_rd("led lone", 8'h56, 16'h0380);
        wr(8'h56, 16'h00c0);
        chk_rd("string_fault_summary_ack", 8'h56, 16'h0000);
        `CHK("irq led off", 1'b0, irq)
        wr(8'h50, 16'h4000);
        chk_rd("global off", 8'h50, 16'h202a);
        hit(7'h40, 6'h00, 1'b0, 1'b0);
        `CHK("irq masked", 1'b0, irq)
        wr(8'h50, 16'h8000);
        chk_rd("en ignored", 8'h50, 16'h202a);
        wr(8'h50, 16'hcc00);
        `CHK("irq unmasked", 1'b1, irq)
        chk_rd("en on", 8'h50, 16'ha82a);
        wr(8'h54, 16'h0003);
        `CHK("irq last", 1'b0, irq)
        print_verdict();
    end
endmodule
